// [ifs_supervisor_regs.vh]
// Register map, field layout, reset values and timing of the fault supervisor.
// Assumes a 10 MHz system clock and a simple strobed register port.
`ifndef IFS_SUPERVISOR_REGS_VH
`define IFS_SUPERVISOR_REGS_VH

// ***********************************************************
// Register byte offsets
// ***********************************************************
`define IFS_ADDR_CTRL     8'h00
`define IFS_ADDR_TEMP     8'h04
`define IFS_ADDR_ZERO     8'h08
`define IFS_ADDR_SPAN     8'h0C
`define IFS_ADDR_STATUS   8'h10
`define IFS_ADDR_MASK     8'h14
`define IFS_ADDR_LOGCNT   8'h18
`define IFS_ADDR_LOGDATA  8'h1C
`define IFS_ADDR_POWER    8'h20
`define IFS_ADDR_STATE    8'h24

// ***********************************************************
// Control register fields
// ***********************************************************
`define IFS_CTRL_STD      0
`define IFS_CTRL_TSEL_LO  1
`define IFS_CTRL_TSEL_HI  2
`define IFS_CTRL_START    3
`define IFS_CTRL_SELFTST  4
`define IFS_CTRL_DEFAULT  5

// Reference temperature selections and values in degrees C
`define IFS_TSEL_25       2'h0
`define IFS_TSEL_20       2'h1
`define IFS_TSEL_0        2'h2
`define IFS_TEMP_25       8'h19
`define IFS_TEMP_20       8'h14
`define IFS_TEMP_0        8'h00

// Factory calibration values in micrograms per cm2
`define IFS_ZERO_DEFAULT  16'h015E
`define IFS_SPAN_DEFAULT  16'h0340

// ***********************************************************
// Status bits and error codes
// ***********************************************************
`define IFS_EV_POWER      0
`define IFS_EV_RESTART    1
`define IFS_EV_INTHW      2
`define IFS_EV_NOZUP      3
`define IFS_EV_NOZDN      4
`define IFS_EV_SHIM       5
`define IFS_EV_TAPE       6
`define IFS_EV_NUM        7
`define IFS_FAULT_MASK    7'h7D

// ***********************************************************
// Timing: clock in Hz, tick and timeouts in seconds, startup in cycles; analog full-scale code
// ***********************************************************
`define IFS_CLK_HZ        10000000
`define IFS_TICK_SEC      1
`define IFS_COMM_SEC      8'h0A
`define IFS_MOTOR_SEC     8'h14
`define IFS_STARTUP_CYC   32'h00000003
`define IFS_FULL_SCALE    16'hFFFF

`endif

// [ifs_supervisor.v]
// Fault supervisor: flow reference temperature, span settings, alarms.
// Assumes one 10 MHz clock; sensor pins arrive asynchronously.
//
// The plain strobed port and the register addresses were left to the implementer.
`timescale 1ns/100ps
`include "ifs_supervisor_regs.vh"
// Behaviour
// - Standard flow uses 25, 20 or 0 C
// - Actual flow uses measured ambient temperature
// - Hold zero value 0.350, unused
// - Hold editable expected membrane span mass
// - Default action restores factory zero and span
// - Check alarms in operation, self-test, cycle start
// - Log time and type; output error code
// - Errors force analog output full scale
// - One shared relay closes on any error
// - Power return raises outage alarm with times; off time clears on return, only on time before failure is kept
// - Supervisor restart is separate non-faulty alarm
// - Ten seconds without I/O link halts
// - Twenty second nozzle move failure halts
// - Nozzle position from single-slot encoder pulse
// - Shim present at startup or start halts
// - Reel driven twenty seconds unrotated: tape broke
module ifs_supervisor
#(
  parameter TICK_CYCLES = `IFS_CLK_HZ * `IFS_TICK_SEC, // Cycles a second
  parameter LOG_DEPTH   = 8,                          // Error log records
  parameter LOG_AW      = 3                           // Log pointer width
)
(
  input  wire        ref_clk,           // System clock, 10 MHz
  input  wire        srst,              // Synchronous reset
  input  wire [7:0]  regAddr,           // Register byte address
  input  wire [31:0] regWdata,          // Register write data
  input  wire        regWr,             // Write strobe
  input  wire        regRd,             // Read strobe
  output reg  [31:0] regRdata,          // Read data, cycle after strobe
  input  wire        nozzleUpDrive,     // Nozzle motor driven up
  input  wire        nozzleDownDrive,   // Nozzle motor driven down
  input  wire        reelDrive,         // Take-up reel motor driven
  input  wire        nozzlePosPin,      // Nozzle slot photo sensor
  input  wire        shimPin,           // Shim presence photo sensor
  input  wire        reelEncPin,        // Supply reel encoder
  input  wire        ioLinkOkPin,       // I/O board link healthy
  input  wire        powerGoodPin,      // Main power present
  input  wire        restartPin,        // Supervisory restart flag
  input  wire [7:0]  ambientTemp,       // Measured ambient, deg C
  input  wire [15:0] concValue,         // Concentration for analog out
  output reg  [7:0]  flowTemp,          // Temperature used for flow
  output reg  [15:0] analogOut,         // Analog concentration code
  output reg         alarmRelay,        // Shared alarm relay closed
  output reg         haltRun,           // Operation halted
  output reg  [7:0]  dataLogCode,       // Code for data-log entry
  output reg         dataLogStrobe,     // Code valid, one cycle
  output wire        irq                // Level interrupt
);
  // ***********************************************************
  // Functions
  // ***********************************************************
  // Reference temperature for a selection
  function [7:0] tempOf;
    input [1:0] sel;
    begin
      tempOf = (sel == `IFS_TSEL_20) ? `IFS_TEMP_20 :
               (sel == `IFS_TSEL_0)  ? `IFS_TEMP_0 : `IFS_TEMP_25;
    end
  endfunction
  // Lowest pending event number, as an error code
  function [7:0] codeOf;
    input [`IFS_EV_NUM-1:0] ev;
    integer i;
    begin
      codeOf = 8'h00;
      for (i = `IFS_EV_NUM - 1; i >= 0; i = i - 1)
        if (ev[i])
          codeOf = i[7:0] + 8'h01;
    end
  endfunction
  // ***********************************************************
  // Registers and state
  // ***********************************************************
  reg                    flowStd;       // Standard flow type
  reg [1:0]              tempSel;       // Reference temperature choice
  reg [15:0]             zeroVal;       // Zero value, stored only
  reg [15:0]             referenceMembraneMass; // Span comparison value
  reg [`IFS_EV_NUM-1:0]  status;        // Sticky alarm bits
  reg [`IFS_EV_NUM-1:0]  mask;          // Interrupt enables
  reg [`IFS_EV_NUM-1:0]  pend;          // Events awaiting logging
  reg [23:0]             logMem [0:LOG_DEPTH-1]; // Time and code
  reg [LOG_AW-1:0]       logWp;         // Log write pointer
  reg [LOG_AW-1:0]       logRp;         // Log read pointer
  reg [LOG_AW:0]         logCnt;        // Records held
  reg [8:0]              syn1;          // Pin sync stage one
  reg [8:0]              syn2;          // Pin sync stage two
  reg [8:0]              synPrev;       // Synced pins, last cycle
  reg [31:0]             tickCnt;       // Divider to one second
  reg                    tick;          // One-second pulse
  reg [15:0]             seconds;       // Free time stamp
  reg [7:0]              commCnt;       // Seconds without link
  reg [7:0]              nozCnt;        // Seconds of nozzle drive
  reg [7:0]              reelCnt;       // Seconds of reel drive
  reg                    commLost;      // Link down ten seconds
  reg [15:0]             onSecs;        // Seconds powered
  reg [15:0]             offSecs;       // Seconds unpowered
  reg [15:0]             onBefore;      // On time before failure
  reg                    startup;       // Set from reset until tickCnt reaches 3
  reg                    nozDirUp;      // Last nozzle direction
  reg [`IFS_EV_NUM-1:0]  evSet;         // Events this cycle
  wire                   nozzleSense;   // Synced nozzle sensor
  wire                   shimSense;     // Synced shim sensor
  wire                   reelSense;     // Synced reel encoder
  wire                   linkOk;        // Synced link health
  wire                   powerGood;     // Synced power flag
  wire                   restartSeen;   // Synced restart flag
  wire                   wrCtrl;        // Control register write
  wire                   cycleCheck;    // Start-of-cycle or self-test
  wire                   errorPresent;  // Any faulty alarm set
  wire                   logPush;       // Record written
  wire                   logPop;        // Record read out
  wire [7:0]             pendCode;      // Code of next record
  assign nozzleSense = syn2[0];
  assign shimSense   = syn2[1];
  assign reelSense   = syn2[2];
  assign linkOk      = syn2[3];
  assign powerGood   = syn2[4];
  assign restartSeen = syn2[5];
  assign wrCtrl      = regWr && (regAddr == `IFS_ADDR_CTRL);
  assign cycleCheck  = wrCtrl && (regWdata[`IFS_CTRL_START] ||
                       regWdata[`IFS_CTRL_SELFTST]);
  assign errorPresent = |(status & `IFS_FAULT_MASK);
  assign irq         = |(status & mask);
  assign pendCode    = codeOf(pend);
  assign logPush     = (|pend) && (logCnt != LOG_DEPTH[LOG_AW:0]);
  assign logPop      = regRd && (regAddr == `IFS_ADDR_LOGDATA) && (|logCnt);
  // ***********************************************************
  // Pin synchronisers and time base
  // ***********************************************************
  // Two flops on every pin before use
  always @(posedge ref_clk)
  begin
    if (srst)
    begin
      syn1    <= 9'h000;
      syn2    <= 9'h000;
      synPrev <= 9'h000;
    end
    else
    begin
      syn1    <= {3'h0, restartPin, powerGoodPin, ioLinkOkPin,
                  reelEncPin, shimPin, nozzlePosPin};
      syn2    <= syn1;
      synPrev <= syn2;
    end
  end
  // One-second tick and time stamp
  always @(posedge ref_clk)
  begin
    if (srst)
    begin
      tickCnt <= 32'h00000000;
      tick    <= 1'b0;
      seconds <= 16'h0000;
    end
    else if (tickCnt == TICK_CYCLES - 1)
    begin
      tickCnt <= 32'h00000000;
      tick    <= 1'b1;
      seconds <= seconds + 16'h0001;
    end
    else
    begin
      tickCnt <= tickCnt + 32'h00000001;
      tick    <= 1'b0;
    end
  end
  // ***********************************************************
  // Supervision timers
  // ***********************************************************
  // Each counter clears when satisfied or drive released
  always @(posedge ref_clk)
  begin
    if (srst)
    begin
      commCnt  <= 8'h00;
      nozCnt   <= 8'h00;
      reelCnt  <= 8'h00;
      commLost <= 1'b0;
      nozDirUp <= 1'b0;
    end
    else
    begin
      // Link: halt level held until link recovers
      if (linkOk)
      begin
        commCnt  <= 8'h00;
        commLost <= 1'b0;
      end
      else if (commCnt >= `IFS_COMM_SEC)
        commLost <= 1'b1;
      else if (tick)
        commCnt <= commCnt + 8'h01;
      // Nozzle: arrival is the slot pulse rising edge
      if (!(nozzleUpDrive || nozzleDownDrive) ||
          (nozzleSense && !synPrev[0]))
        nozCnt <= 8'h00;
      else if (tick && nozCnt < `IFS_MOTOR_SEC)
        nozCnt <= nozCnt + 8'h01;
      if (nozzleUpDrive || nozzleDownDrive)
        nozDirUp <= nozzleUpDrive;
      // Reel: any encoder edge is rotation
      if (!reelDrive || (reelSense != synPrev[2]))
        reelCnt <= 8'h00;
      else if (tick && reelCnt < `IFS_MOTOR_SEC)
        reelCnt <= reelCnt + 8'h01;
    end
  end
  // ***********************************************************
  // Event detection
  // ***********************************************************
  // One-cycle set requests for each alarm
  always @*
  begin
    evSet[`IFS_EV_POWER]   = powerGood && !synPrev[4]
                             && !startup;
    evSet[`IFS_EV_RESTART] = restartSeen && !synPrev[5];
    evSet[`IFS_EV_INTHW]   = !linkOk && commCnt >= `IFS_COMM_SEC
                             && !commLost;
    evSet[`IFS_EV_NOZUP]   = tick && nozDirUp &&
                             nozCnt == `IFS_MOTOR_SEC - 8'h01;
    evSet[`IFS_EV_NOZDN]   = tick && !nozDirUp &&
                             nozCnt == `IFS_MOTOR_SEC - 8'h01;
    evSet[`IFS_EV_SHIM]    = shimSense &&
                             (startup || cycleCheck);
    evSet[`IFS_EV_TAPE]    = tick &&
                             reelCnt == `IFS_MOTOR_SEC - 8'h01;
  end
  // Power on and off durations
  always @(posedge ref_clk)
  begin
    if (srst)
    begin
      onSecs   <= 16'h0000;
      offSecs  <= 16'h0000;
      onBefore <= 16'h0000;
      startup  <= 1'b1;
    end
    else
    begin
      // Startup window lasts until synchronisers are filled
      if (tickCnt == `IFS_STARTUP_CYC)
        startup <= 1'b0;
      if (powerGood && !synPrev[4])
        offSecs <= 16'h0000;
      if (!powerGood && synPrev[4])
      begin
        onBefore <= onSecs;
        onSecs   <= 16'h0000;
      end
      else if (tick && powerGood)
        onSecs <= onSecs + 16'h0001;
      else if (tick && !powerGood)
        offSecs <= offSecs + 16'h0001;
    end
  end
  // ***********************************************************
  // Status, mask, log and outputs
  // ***********************************************************
  // Sticky status: set wins over write-one-to-clear
  always @(posedge ref_clk)
  begin
    if (srst)
    begin
      status <= {`IFS_EV_NUM{1'b0}};
      pend   <= {`IFS_EV_NUM{1'b0}};
    end
    else
    begin
      if (regWr && regAddr == `IFS_ADDR_STATUS)
        status <= (status & ~regWdata[`IFS_EV_NUM-1:0]) | evSet;
      else
        status <= status | evSet;
      if (logPush)
        pend <= (pend & (pend - {{(`IFS_EV_NUM-1){1'b0}}, 1'b1})) | evSet;
      else
        pend <= pend | evSet;
    end
  end
  // Error log ring, one record a cycle
  always @(posedge ref_clk)
  begin
    if (srst)
    begin
      logWp         <= {LOG_AW{1'b0}};
      logRp         <= {LOG_AW{1'b0}};
      logCnt        <= {(LOG_AW+1){1'b0}};
      dataLogCode   <= 8'h00;
      dataLogStrobe <= 1'b0;
    end
    else
    begin
      dataLogStrobe <= logPush;
      if (logPush)
      begin
        logMem[logWp] <= {seconds, pendCode};
        logWp         <= logWp + {{(LOG_AW-1){1'b0}}, 1'b1};
        dataLogCode   <= pendCode;
      end
      if (logPop)
        logRp <= logRp + {{(LOG_AW-1){1'b0}}, 1'b1};
      if (logPush && !logPop)
        logCnt <= logCnt + {{LOG_AW{1'b0}}, 1'b1};
      else if (logPop && !logPush)
        logCnt <= logCnt - {{LOG_AW{1'b0}}, 1'b1};
    end
  end
  // Settings registers
  always @(posedge ref_clk)
  begin
    if (srst)
    begin
      flowStd               <= 1'b0;
      tempSel               <= `IFS_TSEL_25;
      zeroVal               <= `IFS_ZERO_DEFAULT;
      referenceMembraneMass <= `IFS_SPAN_DEFAULT;
      mask                  <= {`IFS_EV_NUM{1'b0}};
    end
    else if (wrCtrl && regWdata[`IFS_CTRL_DEFAULT])
    begin
      zeroVal               <= `IFS_ZERO_DEFAULT;
      referenceMembraneMass <= `IFS_SPAN_DEFAULT;
    end
    else if (wrCtrl)
    begin
      flowStd <= regWdata[`IFS_CTRL_STD];
      // Only the three legal temperatures are accepted
      if (regWdata[`IFS_CTRL_TSEL_HI:`IFS_CTRL_TSEL_LO] != 2'h3)
        tempSel <= regWdata[`IFS_CTRL_TSEL_HI:`IFS_CTRL_TSEL_LO];
    end
    else if (regWr && regAddr == `IFS_ADDR_ZERO)
      zeroVal <= regWdata[15:0];
    else if (regWr && regAddr == `IFS_ADDR_SPAN)
      referenceMembraneMass <= regWdata[15:0];
    else if (regWr && regAddr == `IFS_ADDR_MASK)
      mask <= regWdata[`IFS_EV_NUM-1:0];
  end
  // Block outputs
  always @(posedge ref_clk)
  begin
    if (srst)
    begin
      flowTemp   <= `IFS_TEMP_25;
      analogOut  <= 16'h0000;
      alarmRelay <= 1'b0;
      haltRun    <= 1'b0;
    end
    else
    begin
      flowTemp   <= flowStd ? tempOf(tempSel)
                            : ambientTemp;
      analogOut  <= errorPresent ? `IFS_FULL_SCALE
                                 : concValue;
      alarmRelay <= errorPresent;
      haltRun    <= commLost ||
                    status[`IFS_EV_NOZUP] || status[`IFS_EV_NOZDN] ||
                    status[`IFS_EV_SHIM] ||
                    status[`IFS_EV_TAPE];
    end
  end
  // Read data, one cycle after the strobe; unmapped reads zero
  always @(posedge ref_clk)
  begin
    if (srst || !regRd)
      regRdata <= 32'h00000000;
    else if (regAddr == `IFS_ADDR_CTRL)
      regRdata <= {29'h0, tempSel, flowStd};
    else if (regAddr == `IFS_ADDR_TEMP)
      regRdata <= {24'h0, flowTemp};
    else if (regAddr == `IFS_ADDR_ZERO)
      regRdata <= {16'h0, zeroVal};
    else if (regAddr == `IFS_ADDR_SPAN)
      regRdata <= {16'h0, referenceMembraneMass};
    else if (regAddr == `IFS_ADDR_STATUS)
      regRdata <= {25'h0, status};
    else if (regAddr == `IFS_ADDR_MASK)
      regRdata <= {25'h0, mask};
    else if (regAddr == `IFS_ADDR_LOGCNT)
      regRdata <= {{(31-LOG_AW){1'b0}}, logCnt};
    else if (regAddr == `IFS_ADDR_LOGDATA)
      regRdata <= logPop ? {8'h0, logMem[logRp]} : 32'h00000000;
    else if (regAddr == `IFS_ADDR_POWER)
      regRdata <= {offSecs, onBefore};
    else if (regAddr == `IFS_ADDR_STATE)
      regRdata <= {29'h0, commLost, haltRun, alarmRelay};
    else
      regRdata <= 32'h00000000;
  end
endmodule

// [ifs_supervisor_chk.sv]
// Port checker for the fault supervisor.
// Assumes one ref_clk domain; bound to every supervisor instance.
`timescale 1ns/100ps
`include "ifs_supervisor_regs.vh"
module ifs_supervisor_chk
#(
  parameter TICK_CYCLES = 10                // Cycles a second
)
(
  input wire logic        ref_clk,          // Clock
  input wire logic        srst,             // Reset
  input wire logic [7:0]  regAddr,          // Address
  input wire logic [31:0] regWdata,         // Write data
  input wire logic        regWr,            // Write strobe
  input wire logic        regRd,            // Read strobe
  input wire logic [31:0] regRdata,         // Read data
  input wire logic        nozzleUpDrive,    // Up drive
  input wire logic        nozzleDownDrive,  // Down drive
  input wire logic        reelDrive,        // Reel drive
  input wire logic        nozzlePosPin,     // Slot sensor
  input wire logic        shimPin,          // Shim sensor
  input wire logic        reelEncPin,       // Reel encoder
  input wire logic        ioLinkOkPin,      // Link healthy
  input wire logic [7:0]  ambientTemp,      // Ambient
  input wire logic [7:0]  flowTemp,         // Flow temperature
  input wire logic [15:0] analogOut,        // Analog code
  input wire logic        alarmRelay,       // Relay
  input wire logic        haltRun,          // Halted
  input wire logic [7:0]  dataLogCode,      // Log code
  input wire logic        dataLogStrobe     // Log strobe
);
  // ********************************
  // Helper counters
  // ********************************
  localparam int LIM_LINK  = 11 * TICK_CYCLES + 4; // Link loss, with slack
  localparam int LIM_MOTOR = 21 * TICK_CYCLES + 4; // Motor wait, with slack
  logic [15:0] lowCnt;   // Link low cycles
  logic [15:0] nozCnt;   // Nozzle driven, no arrival
  logic [15:0] reelCnt;  // Reel driven, no rotation
  logic        posLast;  // Slot sensor, last cycle
  logic        encLast;  // Encoder, last cycle

  function automatic logic [7:0] tempOf(input logic [1:0] s);
    tempOf = s == 2'h0 ? 8'h19 : (s == 2'h1 ? 8'h14 : 8'h00);
  endfunction

  // Count time spent waiting on each monitored condition
  always @(posedge ref_clk)
  begin
    posLast <= nozzlePosPin;
    encLast <= reelEncPin;
    lowCnt <= (srst || ioLinkOkPin) ? 16'h0000 : lowCnt + 16'h0001;
    if (srst || !(nozzleUpDrive || nozzleDownDrive) ||
        (nozzlePosPin && !posLast))
      nozCnt <= 16'h0000;
    else
      nozCnt <= nozCnt + 16'h0001;
    if (srst || !reelDrive || reelEncPin != encLast)
      reelCnt <= 16'h0000;
    else
      reelCnt <= reelCnt + 16'h0001;
  end

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (srst);

  // ********************************
  // Assertions
  // ********************************
  a_reset_outputs: assert property ($fell(srst) |->
    flowTemp == 8'h19 && !alarmRelay && !haltRun)
    else $error("outputs wrong after reset");
  a_read_idle: assert property (!regRd |=> regRdata == 32'h0)
    else $error("read data not zero when idle");
  a_std_temp: assert property (regWr && regAddr == `IFS_ADDR_CTRL &&
    regWdata[0] && !regWdata[5] && regWdata[2:1] != 2'h3
    |-> ##2 flowTemp == tempOf($past(regWdata[2:1], 2)))
    else $error("standard temp wrong");
  a_actual_temp: assert property (regWr && regAddr == `IFS_ADDR_CTRL &&
    !regWdata[0] && !regWdata[5] |-> ##2 flowTemp == ambientTemp)
    else $error("actual temp wrong");
  a_fault_full_scale: assert property (alarmRelay [*2] |->
    analogOut == 16'hFFFF) else $error("analog not full scale");
  a_log_code_range: assert property (dataLogStrobe |->
    dataLogCode >= 8'h01 && dataLogCode <= 8'h07)
    else $error("log code out of range");
  a_link_halt: assert property (lowCnt >= LIM_LINK |-> haltRun)
    else $error("no halt after link loss");
  a_nozzle_halt: assert property (nozCnt >= LIM_MOTOR |->
    haltRun && alarmRelay) else $error("no halt after nozzle stall");
  a_reel_halt: assert property (reelCnt >= LIM_MOTOR |->
    haltRun && alarmRelay) else $error("no halt after tape break");
  a_shim_halt: assert property (shimPin && $past(shimPin, 4) &&
    regWr && regAddr == `IFS_ADDR_CTRL && (regWdata[3] || regWdata[4])
    |-> ##[1:8] haltRun) else $error("no halt with shim present");
  c_reel_stall: cover property (reelCnt >= LIM_MOTOR);
  c_link_loss: cover property (lowCnt >= LIM_LINK);
  c_log_entry: cover property (dataLogStrobe);
endmodule

bind ifs_supervisor ifs_supervisor_chk #(.TICK_CYCLES(TICK_CYCLES)) i_chk (.*);

// [ifs_field_model.sv]
// Behavioural nozzle motor and tape reel with their sensors.
// Assumes drives arrive on ref_clk; faults are chosen by the bench.
`timescale 1ns/100ps
module ifs_field_model
#(
  parameter ARRIVE = 120                    // Drive cycles to reach a stop
)
(
  input  wire logic ref_clk,                // Clock
  input  wire logic nozzleUpDrive,          // Up drive
  input  wire logic nozzleDownDrive,        // Down drive
  input  wire logic reelDrive,              // Reel drive
  input  wire logic nozzleStuck,            // Nozzle motor seized
  input  wire logic reelStuck,              // Tape broken
  output logic      nozzlePosPin,           // Slot sensor
  output logic      reelEncPin              // Supply reel encoder
);
  int moveCnt = 0;                          // Cycles of nozzle drive
  int encCnt = 0;                           // Cycles of reel rotation
  initial nozzlePosPin = 1'b0;
  // Single slot passes the sensor once per move; encoder frozen if broken
  always @(posedge ref_clk)
  begin
    moveCnt <= (nozzleUpDrive || nozzleDownDrive) ? moveCnt + 1 : 0;
    nozzlePosPin <= !nozzleStuck && moveCnt >= ARRIVE &&
                    moveCnt < ARRIVE + 3;
    encCnt <= (reelDrive && !reelStuck) ? encCnt + 1 : encCnt;
  end
  assign reelEncPin = encCnt[3];
endmodule

// [instrument_fault_supervisor_test.sv]
// Self-checking bench for the fault supervisor.
// Assumes the supervisor, its checker and the field model alongside.
`timescale 1ns/100ps
`include "ifs_supervisor_regs.vh"
module instrument_fault_supervisor_test;
  localparam int TICK = 10;             // Short second for simulation
  logic        ref_clk = 0, srst = 1;   // Clock, reset
  logic [7:0]  regAddr = 8'h00;         // Address
  logic [31:0] regWdata = 32'h0;        // Write data
  logic        regWr = 0, regRd = 0;    // Strobes
  logic        nozzleUpDrive = 0, nozzleDownDrive = 0, reelDrive = 0;
  logic        shimPin = 0, restartPin = 0; // Sensors
  logic        ioLinkOkPin = 1, powerGoodPin = 1; // Healthy
  logic        nozzleStuck = 0, reelStuck = 0; // Model faults
  logic [31:0] seed = 32'hFA42;         // Random state
  logic [7:0]  ambientTemp;             // Ambient
  logic [15:0] concValue;               // Concentration
  logic [7:0]  tbl [3] = '{8'h19, 8'h14, 8'h00}; // 25, 20, 0 C
  wire  [31:0] regRdata;                // Read data
  wire  [15:0] analogOut;               // Analog code
  wire  [7:0]  flowTemp, dataLogCode;   // Temp, log code
  wire         nozzlePosPin, reelEncPin, alarmRelay, haltRun;
  wire         dataLogStrobe, irq;      // Log strobe, interrupt
  logic [31:0] expQ [$];                    // Expected read data
  logic        rdPend = 0;                  // Read answer due
  int          err_count = 0, tests_run = 0, cyc = 0;

  ifs_supervisor #(.TICK_CYCLES(TICK)) i_ifs_supervisor (.*);
  ifs_field_model i_ifs_field_model (.*);

  always #50 ref_clk = ~ref_clk;            // 10 MHz

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic check(input string nm, input logic [31:0] seen,
                       input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task give_verdict;
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // Answers to reads, compared with the oldest note; hang guard
  always @(posedge ref_clk)
  begin
    if (rdPend)
      check("regRdata", regRdata, expQ.pop_front());
    rdPend <= regRd;
    cyc++;
    if (cyc == 4000)
    begin
      err_count++;
      give_verdict();
    end
  end

  task idle(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    regWr <= 1;
    regAddr <= a;
    regWdata <= d;
    @(posedge ref_clk);
    regWr <= 0;
  endtask

  task rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge ref_clk);
    regRd <= 1;
    regAddr <= a;
    expQ.push_back(e);
    @(posedge ref_clk);
    regRd <= 0;
  endtask

  // One alarm seen in status, state, irq, relay, analog output and log code, then cleared by writing one
  task alarm(input int b, input logic relay, input logic [2:0] st);
    idle(6);
    rd(`IFS_ADDR_STATUS, 32'h1 << b);
    rd(`IFS_ADDR_STATE, {29'h0, st});
    check("irq", 32'(irq), 32'h1);
    check("alarmRelay", 32'(alarmRelay), 32'(relay));
    check("analogOut", 32'(analogOut), relay ? 32'hFFFF : 32'(concValue));
    check("dataLogCode", 32'(dataLogCode), 32'(b + 1));
    wr(`IFS_ADDR_STATUS, 32'h1 << b);
    idle(3);
    check("irqCleared", 32'(irq), 32'h0);
  endtask

  task pulseRestart;
    restartPin <= 1;
    idle(4);
    restartPin <= 0;
  endtask

  // Main sequence
  initial
  begin
    seed = lfsr(seed);
    ambientTemp = seed[7:0];
    concValue = seed[23:8];
    idle(5);
    check("flowTemp", 32'(flowTemp), 32'h19);
    srst <= 0;
    idle(1);
    rd(`IFS_ADDR_ZERO, 32'h015E);
    rd(`IFS_ADDR_SPAN, 32'h0340);
    for (int i = 0; i < 4; i++)
    begin
      wr(`IFS_ADDR_CTRL, 32'(i * 2 + 1));
      idle(3);
      rd(`IFS_ADDR_TEMP, 32'(tbl[i > 2 ? 2 : i]));
    end
    wr(`IFS_ADDR_CTRL, 32'h0);
    idle(3);
    rd(`IFS_ADDR_TEMP, 32'(ambientTemp));
    seed = lfsr(seed);
    wr(`IFS_ADDR_SPAN, {16'h0, seed[15:0]});
    rd(`IFS_ADDR_SPAN, {16'h0, seed[15:0]});
    wr(`IFS_ADDR_ZERO, 32'h1234);
    wr(`IFS_ADDR_CTRL, 32'h20);
    rd(`IFS_ADDR_ZERO, 32'h015E);
    rd(`IFS_ADDR_SPAN, 32'h0340);
    rd(8'h3C, 32'h0);
    wr(`IFS_ADDR_MASK, 32'h7F);
    for (int f = 0; f < 2; f++)
    begin
      reelStuck <= f[0];
      reelDrive <= 1;
      idle(25 * TICK);
      reelDrive <= 0;
      if (f == 0) rd(`IFS_ADDR_STATUS, 32'h0);
      else alarm(6, 1, 3'b011);
    end
    for (int f = 0; f < 3; f++)
    begin
      nozzleStuck <= f > 0;
      nozzleUpDrive <= f < 2;
      nozzleDownDrive <= f == 2;
      idle(25 * TICK);
      nozzleUpDrive <= 0;
      nozzleDownDrive <= 0;
      if (f == 0) rd(`IFS_ADDR_STATUS, 32'h0);
      else alarm(2 + f, 1, 3'b011);
    end
    for (int f = 0; f < 2; f++)
    begin
      ioLinkOkPin <= 0;
      idle(f ? 12 * TICK : 8 * TICK);
      if (f) rd(`IFS_ADDR_STATE, 32'h7);
      ioLinkOkPin <= 1;
      if (f) alarm(2, 1, 3'b001);
      else rd(`IFS_ADDR_STATUS, 32'h0);
    end
    for (int s = 3; s < 5; s++)
    begin
      shimPin <= 1;
      idle(6);
      wr(`IFS_ADDR_CTRL, 32'h1 << s);
      idle(6);
      shimPin <= 0;
      alarm(5, 1, 3'b011);
    end
    pulseRestart();
    alarm(1, 0, 3'b000);
    powerGoodPin <= 0;
    idle(30);
    powerGoodPin <= 1;
    alarm(0, 1, 3'b001);
    wr(`IFS_ADDR_MASK, 32'h0);
    pulseRestart();
    idle(6);
    check("irqMasked", 32'(irq), 32'h0);
    rd(`IFS_ADDR_STATUS, 32'h2);
    idle(3);
    give_verdict();
  end
endmodule
